// ===== sim/dbgbuf_asserts.sv
// Checker of the debug buffer register port.
`timescale 1ns/10ps
`include "dbgbuf_consts.svh"
module dbgbuf_asserts (
  // CPU side
  input wire logic                     clk,
  input wire logic                     resetn,
  input wire logic [3:0]               reg_mod,
  input wire logic [4:0]               reg_idx,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire dbgbuf_pkg::dbgbuf_word_t reg_wdata,
  input wire dbgbuf_pkg::dbgbuf_word_t reg_rdata,
  input wire logic                     spe_in,
  input wire logic                     tap_status_clear,
  // TAP side
  input wire logic                     tdo_oe,
  input wire logic                     tlr_active
);
  import dbgbuf_pkg::*;
  logic m0, rd_f, rd_h, rd_a, wr_f, wr_h;
  assign m0   = reg_mod == `DBGBUF_MOD_DEBUG;
  assign rd_f = reg_rd && m0 && reg_idx == `DBGBUF_IDX_FLAG;
  assign rd_h = reg_rd && m0 && reg_idx == `DBGBUF_IDX_HOLD;
  assign rd_a = reg_rd && m0 && reg_idx == `DBGBUF_IDX_ADDR;
  assign wr_f = reg_wr && m0 && reg_idx == `DBGBUF_IDX_FLAG;
  assign wr_h = reg_wr && m0 && reg_idx == `DBGBUF_IDX_HOLD;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_rsv_zero: assert property (rd_f |=> reg_rdata[15:2] == 14'h0000)
    else $error("flag reserved bits not zero");
  a_spe_shown: assert property (rd_f |=> reg_rdata[1] == $past(spe_in))
    else $error("flag bit 1 differs from spe_in");
  a_hold_tlr: assert property (tlr_active [*3] ##0 rd_h |=> reg_rdata == 16'h0000)
    else $error("hold buffer not clear in reset state");
  a_addr_tlr: assert property (tlr_active [*3] ##0 rd_a |=> reg_rdata == 16'hffff)
    else $error("address word not all ones in reset state");
  a_hold_rw: assert property (!tlr_active [*3] ##0 wr_h ##2 rd_h
    |=> reg_rdata == {8'h00, $past(reg_wdata[7:0], 3)})
    else $error("hold buffer read differs from write");
  a_idle_zero: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero when idle");
  a_unmapped_zero: assert property (reg_rd && !(rd_f || rd_h || rd_a)
    |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_clear_pulse: assert property (!tlr_active [*3] ##0 wr_f |=> tap_status_clear)
    else $error("flag write gave no clear pulse");
  a_clear_cause: assert property (tap_status_clear |-> $past(wr_f))
    else $error("clear pulse without flag write");
  a_oe_tlr: assert property (tlr_active |-> !tdo_oe)
    else $error("tdo driven in reset state");
  c_hold_wr: cover property (wr_h);
  c_clear: cover property (tap_status_clear);
  c_shift: cover property ($rose(tdo_oe));
endmodule // dbgbuf_asserts
bind dbgbuf_top dbgbuf_asserts u_dbgbuf_asserts (.clk(clk), .resetn(resetn),
  .reg_mod(reg_mod), .reg_idx(reg_idx), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .spe_in(spe_in),
  .tap_status_clear(tap_status_clear), .tdo_oe(tdo_oe), .tlr_active(tlr_active));

// ===== sim/dbgbuf_host.sv
// Debug host model driving the TAP pins.
`timescale 1ns/10ps
module dbgbuf_host (
  // TAP pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic tdo_s;
  // The link clock stands low between calls, as a real probe would leave it.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic tick(input logic m, input logic d);
    tms = m;
    tdi = d;
    #40;
    tdo_s = tdo_oe ? tdo : 1'bz;
    tck = 1'b1;
    #40;
    tck = 1'b0;
  endtask
  // Outside the shift bits tdi toggles so no stale value can look valid.
  task automatic shift(input logic ir, input logic [7:0] v, input int n,
                       output logic [7:0] got);
    tick(1'b1, ~tdi);
    if (ir) tick(1'b1, ~tdi);
    tick(1'b0, ~tdi);
    tick(1'b0, ~tdi);
    got = 8'h00;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, v[i]);
      got[i] = tdo_s;
    end
    tick(1'b1, ~tdi);
    tick(1'b0, ~tdi);
  endtask
endmodule // dbgbuf_host

// ===== sim/tb.sv
// Self-checking bench for the debug buffer block.
`timescale 1ns/10ps
`include "dbgbuf_consts.svh"
module tb;
  import dbgbuf_pkg::*;
  logic         clk, resetn, reg_wr, reg_rd, spe_in, rd_q, tap_status_clear;
  logic         tck, tms, tdi, tdo, tdo_oe, tlr_active;
  logic [3:0]   reg_mod;
  logic [4:0]   reg_idx;
  dbgbuf_word_t reg_wdata, reg_rdata, w, exp_q[$];
  dbgbuf_byte_t hb, xb, lo, hi, got;
  int           num_errors = 0;
  int           n_checks = 0;
  dbgbuf_top u_dbgbuf_top (.clk(clk), .resetn(resetn), .reg_mod(reg_mod),
    .reg_idx(reg_idx), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .spe_in(spe_in), .tap_status_clear(tap_status_clear),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .tlr_active(tlr_active));
  dbgbuf_host u_dbgbuf_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input dbgbuf_word_t e, input dbgbuf_word_t g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic sync(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // A read notes its expected word; the monitor below compares it.
  task automatic acc(input logic wr, input logic [3:0] m, input logic [4:0] i,
                     input dbgbuf_word_t d);
    reg_mod = m;
    reg_idx = i;
    reg_wdata = d;
    if (wr) reg_wr = 1'b1;
    else begin
      reg_rd = 1'b1;
      exp_q.push_back(d);
    end
    sync(1);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sync(1);
  endtask
  always @(posedge clk) rd_q <= reg_rd;
  always @(negedge clk) if (rd_q === 1'b1) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    {resetn, reg_wr, reg_rd, reg_mod, reg_idx, reg_wdata} = '0;
    void'($urandom(42));
    spe_in = 1'($urandom);
    fork
      u_dbgbuf_host.tick(1'b1, 1'b0);
      repeat (12) @(posedge clk);
    join
    #1 resetn = 1'b1;
    sync(4);
    acc(1, 4'h0, `DBGBUF_IDX_HOLD, 16'h005a);
    acc(0, 4'h0, `DBGBUF_IDX_HOLD, 16'h0000);
    acc(0, 4'h0, `DBGBUF_IDX_ADDR, 16'hffff);
    acc(0, 4'h0, `DBGBUF_IDX_FLAG, {14'h0, spe_in, 1'b0});
    u_dbgbuf_host.tick(1'b0, 1'b1);
    sync(6);
    w = 16'($urandom);
    hb = w[7:0];
    acc(1, 4'h0, `DBGBUF_IDX_HOLD, w);
    acc(0, 4'h0, `DBGBUF_IDX_HOLD, {8'h00, hb});
    acc(1, 4'h0, `DBGBUF_IDX_ADDR, w);
    acc(0, 4'h0, `DBGBUF_IDX_ADDR, 16'hffff);
    acc(0, 4'h0, 5'h1e, 16'h0000);
    acc(0, 4'h1, `DBGBUF_IDX_HOLD, 16'h0000);
    xb = 8'($urandom);
    lo = 8'($urandom);
    hi = 8'($urandom);
    u_dbgbuf_host.shift(1'b1, 8'(`DBGBUF_CMD_DATA), 3, got);
    u_dbgbuf_host.shift(1'b0, xb, 8, got);
    chk("tap_out", {8'h00, hb}, {8'h00, got});
    sync(10);
    acc(0, 4'h0, `DBGBUF_IDX_HOLD, {8'h00, xb});
    acc(0, 4'h0, `DBGBUF_IDX_FLAG, {14'h0, spe_in, 1'b1});
    acc(1, 4'h0, `DBGBUF_IDX_FLAG, 16'h0000);
    acc(0, 4'h0, `DBGBUF_IDX_FLAG, {14'h0, spe_in, 1'b0});
    u_dbgbuf_host.shift(1'b1, 8'(`DBGBUF_CMD_ADDR_LO), 3, got);
    u_dbgbuf_host.shift(1'b0, lo, 8, got);
    chk("tap_out", {8'h00, xb}, {8'h00, got});
    u_dbgbuf_host.shift(1'b1, 8'(`DBGBUF_CMD_ADDR_HI), 3, got);
    u_dbgbuf_host.shift(1'b0, hi, 8, got);
    u_dbgbuf_host.shift(1'b1, 8'(`DBGBUF_CMD_DATA), 3, got);
    u_dbgbuf_host.shift(1'b0, ~xb, 7, got);
    sync(10);
    acc(0, 4'h0, `DBGBUF_IDX_ADDR, {hi, lo});
    acc(0, 4'h0, `DBGBUF_IDX_HOLD, {8'h00, xb});
    repeat (5) u_dbgbuf_host.tick(1'b1, 1'b0);
    sync(8);
    acc(0, 4'h0, `DBGBUF_IDX_HOLD, 16'h0000);
    acc(0, 4'h0, `DBGBUF_IDX_ADDR, 16'hffff);
    report_and_stop();
  end
endmodule // tb

// ===== src/dbgbuf_consts.svh
// Offsets, field positions, reset values and widths of the debug buffer block.
`ifndef DBGBUF_CONSTS_SVH
`define DBGBUF_CONSTS_SVH
`define DBGBUF_IDX_FLAG      5'h1b
`define DBGBUF_IDX_HOLD      5'h1c
`define DBGBUF_IDX_ADDR      5'h1d
`define DBGBUF_MOD_DEBUG     4'h0
`define DBGBUF_HOLD_RST      8'h00
`define DBGBUF_ADDR_RST      16'hffff
`define DBGBUF_FLAG_TXC_BIT  0
`define DBGBUF_FLAG_SPE_BIT  1
`define DBGBUF_FLAG_RSV_MASK 8'hfc
`define DBGBUF_SHIFT_LEN     4'h8
`define DBGBUF_IR_LEN        3'h3
`define DBGBUF_CMD_DATA      3'h1
`define DBGBUF_CMD_ADDR_LO   3'h2
`define DBGBUF_CMD_ADDR_HI   3'h3
`endif

// ===== src/dbgbuf_fifo2.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/10ps
module dbgbuf_fifo2 (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  flush,
  // Fill side
  input  wire logic                  in_valid,
  output logic                       in_ready,
  input  wire dbgbuf_pkg::dbgbuf_byte_t in_data,
  // Drain side
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output dbgbuf_pkg::dbgbuf_byte_t   out_data
);
  import dbgbuf_pkg::*;
  typedef struct packed {
    dbgbuf_byte_t [1:0] mem;
    logic [1:0]         cnt;
  } dbgbuf_fifo_s;
  dbgbuf_fifo_s st_r, st_nxt;
  logic push, pop;
  assign in_ready  = (st_r.cnt != 2'h2);
  assign out_valid = (st_r.cnt != 2'h0);
  assign out_data  = st_r.mem[0];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_comb begin
    st_nxt = st_r;
    if (pop) begin
      st_nxt.mem[0] = st_r.mem[1];
    end
    if (push) begin
      if (st_r.cnt == 2'h0 || (st_r.cnt == 2'h1 && pop)) begin
        st_nxt.mem[0] = in_data;
      end else begin
        st_nxt.mem[1] = in_data;
      end
    end
    st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
    if (flush) begin
      st_nxt.cnt = 2'h0;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // dbgbuf_fifo2

// ===== src/dbgbuf_pkg.sv
// Types shared by the debug buffer block.
package dbgbuf_pkg;
  typedef logic [7:0]  dbgbuf_byte_t;
  typedef logic [15:0] dbgbuf_word_t;
  typedef enum logic [3:0] {
    DBGBUF_TLR, DBGBUF_RTI, DBGBUF_SEL_DR, DBGBUF_CAP_DR, DBGBUF_SH_DR, DBGBUF_EX1_DR,
    DBGBUF_PA_DR, DBGBUF_EX2_DR, DBGBUF_UPD_DR, DBGBUF_SEL_IR, DBGBUF_CAP_IR,
    DBGBUF_SH_IR, DBGBUF_EX1_IR, DBGBUF_PA_IR, DBGBUF_EX2_IR, DBGBUF_UPD_IR
  } dbgbuf_tap_e;
endpackage

// ===== src/dbgbuf_top.sv
// Debug holding buffer, debug address word and flag byte behind the TAP.
// Operation
// - Flag byte bits 7 to 2 always read as zero.
// - The holding buffer clears to zero on power-on reset and on Test-Logic-Reset.
// - The CPU may read the holding buffer at any time and write it outside Test-Logic-Reset.
// - The holding buffer is the parallel load and unload stage of the TAP debug shift register.
// - The holding buffer decodes at index 1Ch of register module 0.
// - The address word sets to all ones on power-on reset and on Test-Logic-Reset.
// - The CPU reads the address word freely but its writes leave it unchanged.
// - The address word loads only through a valid debug command over the TAP.
// - Hardware sets the transfer complete flag when a TAP transfer cycle ends.
`timescale 1ns/10ps
`include "dbgbuf_consts.svh"
module dbgbuf_top (
  // CPU clock and power-on reset
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // CPU register port
  input  wire logic [3:0]              reg_mod,
  input  wire logic [4:0]              reg_idx,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire dbgbuf_pkg::dbgbuf_word_t reg_wdata,
  output dbgbuf_pkg::dbgbuf_word_t     reg_rdata,
  input  wire logic                    spe_in,
  output logic                         tap_status_clear,
  // TAP pins
  input  wire logic                    tck,
  input  wire logic                    tms,
  input  wire logic                    tdi,
  output logic                         tdo,
  output logic                         tdo_oe,
  // Observed state
  output logic                         tlr_active
);
  import dbgbuf_pkg::*;

  // TAP domain state.
  typedef struct packed {
    dbgbuf_tap_e  tap;
    logic [2:0]   ir_sh;
    logic [2:0]   ir;
    dbgbuf_byte_t dr_sh;
    logic [3:0]   bits;
    dbgbuf_word_t addr;
    logic         addr_tgl;
    logic         done_tgl;
    logic         out_ack_tgl;
    logic         in_push_tgl;
    logic [2:0]   ack_sync;
    dbgbuf_byte_t hold_t;
  } dbgbuf_tck_s;

  // CPU domain state.
  typedef struct packed {
    dbgbuf_byte_t hold;
    dbgbuf_word_t addr;
    logic         transfer_complete_flag;
    logic [2:0]   addr_sync;
    logic [2:0]   done_sync;
    logic [2:0]   push_sync;
    logic [1:0]   tlr_sync;
    logic         out_tgl;
    logic         out_busy;
    dbgbuf_byte_t hold_x;
    logic         hold_dirty;
    logic [2:0]   oack_sync;
    dbgbuf_word_t rdata;
    logic         clr;
  } dbgbuf_cpu_s;

  dbgbuf_tck_s t_r, t_nxt;
  dbgbuf_cpu_s c_r, c_nxt;

  logic         tx_valid, tx_ready, rx_valid, rx_ready;
  dbgbuf_byte_t rx_data;
  logic         tlr_now;

  function automatic dbgbuf_tap_e tap_step(input dbgbuf_tap_e s, input logic m);
    case (s)
      DBGBUF_TLR:     tap_step = m ? DBGBUF_TLR : DBGBUF_RTI;
      DBGBUF_RTI:     tap_step = m ? DBGBUF_SEL_DR : DBGBUF_RTI;
      DBGBUF_SEL_DR:  tap_step = m ? DBGBUF_SEL_IR : DBGBUF_CAP_DR;
      DBGBUF_CAP_DR:  tap_step = m ? DBGBUF_EX1_DR : DBGBUF_SH_DR;
      DBGBUF_SH_DR:   tap_step = m ? DBGBUF_EX1_DR : DBGBUF_SH_DR;
      DBGBUF_EX1_DR:  tap_step = m ? DBGBUF_UPD_DR : DBGBUF_PA_DR;
      DBGBUF_PA_DR:   tap_step = m ? DBGBUF_EX2_DR : DBGBUF_PA_DR;
      DBGBUF_EX2_DR:  tap_step = m ? DBGBUF_UPD_DR : DBGBUF_SH_DR;
      DBGBUF_UPD_DR:  tap_step = m ? DBGBUF_SEL_DR : DBGBUF_RTI;
      DBGBUF_SEL_IR:  tap_step = m ? DBGBUF_TLR : DBGBUF_CAP_IR;
      DBGBUF_CAP_IR:  tap_step = m ? DBGBUF_EX1_IR : DBGBUF_SH_IR;
      DBGBUF_SH_IR:   tap_step = m ? DBGBUF_EX1_IR : DBGBUF_SH_IR;
      DBGBUF_EX1_IR:  tap_step = m ? DBGBUF_UPD_IR : DBGBUF_PA_IR;
      DBGBUF_PA_IR:   tap_step = m ? DBGBUF_EX2_IR : DBGBUF_PA_IR;
      DBGBUF_EX2_IR:  tap_step = m ? DBGBUF_UPD_IR : DBGBUF_SH_IR;
      DBGBUF_UPD_IR:  tap_step = m ? DBGBUF_SEL_DR : DBGBUF_RTI;
      default:        tap_step = DBGBUF_TLR;
    endcase
  endfunction

  function automatic logic tgl_edge(input logic [2:0] s);
    tgl_edge = s[2] ^ s[1];
  endfunction

  // Bytes captured by the TAP pass through this buffer; rx_ready is tied high, so each reaches the holding buffer one clk cycle later.
  // The handshake toggles make tx_valid and tx_ready CPU-domain signals.
  // The shift register stands still until the next Capture-DR, long after the push has crossed.
  dbgbuf_fifo2 u_rxbuf (
    .clk       (clk),
    .resetn    (resetn),
    .flush     (c_r.tlr_sync[1]),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (t_r.dr_sh),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // TAP side, clocked by tck.
  assign tlr_now = (t_r.tap == DBGBUF_TLR);

  always_comb begin
    t_nxt          = t_r;
    t_nxt.tap      = tap_step(t_r.tap, tms);
    t_nxt.ack_sync = {t_r.ack_sync[1:0], c_r.out_tgl};
    case (t_r.tap)
      DBGBUF_TLR: begin
        t_nxt.ir     = 3'h0;
        t_nxt.addr   = `DBGBUF_ADDR_RST;
        t_nxt.hold_t = `DBGBUF_HOLD_RST;
      end
      DBGBUF_CAP_IR: begin
        t_nxt.ir_sh = 3'h1;
      end
      DBGBUF_SH_IR: begin
        t_nxt.ir_sh = {tdi, t_r.ir_sh[2:1]};
      end
      DBGBUF_UPD_IR: begin
        t_nxt.ir = t_r.ir_sh;
      end
      DBGBUF_CAP_DR: begin
        // Parallel load from the holding buffer.
        t_nxt.dr_sh = t_r.hold_t;
        t_nxt.bits  = 4'h0;
      end
      DBGBUF_SH_DR: begin
        t_nxt.dr_sh = {tdi, t_r.dr_sh[7:1]};
        if (t_r.bits != `DBGBUF_SHIFT_LEN) begin
          t_nxt.bits = t_r.bits + 4'h1;
        end
      end
      DBGBUF_UPD_DR: begin
        if (t_r.bits == `DBGBUF_SHIFT_LEN) begin
          // Only a whole byte under a known command counts as a transfer.
          if (t_r.ir == `DBGBUF_CMD_DATA) begin
            t_nxt.in_push_tgl = ~t_r.in_push_tgl;
            t_nxt.done_tgl    = ~t_r.done_tgl;
          end else if (t_r.ir == `DBGBUF_CMD_ADDR_LO) begin
            t_nxt.addr[7:0] = t_r.dr_sh;
            t_nxt.addr_tgl  = ~t_r.addr_tgl;
            t_nxt.done_tgl  = ~t_r.done_tgl;
          end else if (t_r.ir == `DBGBUF_CMD_ADDR_HI) begin
            t_nxt.addr[15:8] = t_r.dr_sh;
            t_nxt.addr_tgl   = ~t_r.addr_tgl;
            t_nxt.done_tgl   = ~t_r.done_tgl;
          end
        end
      end
      default: begin
      end
    endcase
    // The snapshot is copied only after its toggle has crossed, so it cannot tear.
    if (tgl_edge(t_r.ack_sync)) begin
      t_nxt.hold_t      = c_r.hold_x;
      t_nxt.out_ack_tgl = ~t_r.out_ack_tgl;
    end
  end

  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      t_r      <= '0;
      t_r.tap  <= DBGBUF_TLR;
      t_r.addr <= `DBGBUF_ADDR_RST;
    end else begin
      t_r <= t_nxt;
    end
  end

  // TDO changes on the falling edge so the host samples a settled bit.
  logic tdo_r;
  always_ff @(negedge tck or negedge resetn) begin
    if (!resetn) begin
      tdo_r <= 1'b0;
    end else begin
      tdo_r <= t_r.dr_sh[0];
    end
  end
  assign tdo    = tdo_r;
  assign tdo_oe = (t_r.tap == DBGBUF_SH_DR);

  // CPU side.
  assign tx_valid = tgl_edge(c_r.push_sync);
  assign rx_ready = 1'b1;

  always_comb begin
    c_nxt           = c_r;
    c_nxt.tlr_sync  = {c_r.tlr_sync[0], tlr_now};
    c_nxt.addr_sync = {c_r.addr_sync[1:0], t_r.addr_tgl};
    c_nxt.done_sync = {c_r.done_sync[1:0], t_r.done_tgl};
    c_nxt.push_sync = {c_r.push_sync[1:0], t_r.in_push_tgl};
    c_nxt.clr       = 1'b0;
    // The address word is stable for several tck periods after its toggle.
    if (tgl_edge(c_r.addr_sync)) begin
      c_nxt.addr = t_r.addr;
    end
    if (rx_valid) begin
      c_nxt.hold = rx_data;
    end
    if (reg_wr && reg_mod == `DBGBUF_MOD_DEBUG) begin
      if (reg_idx == `DBGBUF_IDX_HOLD) begin
        c_nxt.hold = reg_wdata[7:0];
      end else if (reg_idx == `DBGBUF_IDX_FLAG) begin
        if (!reg_wdata[`DBGBUF_FLAG_TXC_BIT]) begin
          c_nxt.transfer_complete_flag = 1'b0;
        end
        c_nxt.clr = 1'b1;
      end
      // Writes to the address word index are dropped.
    end
    if (tgl_edge(c_r.done_sync)) begin
      c_nxt.transfer_complete_flag = 1'b1;
    end
    if (c_r.tlr_sync[1]) begin
      c_nxt.hold = `DBGBUF_HOLD_RST;
      c_nxt.addr = `DBGBUF_ADDR_RST;
      c_nxt.transfer_complete_flag  = 1'b0;
    end
    // A changed holding buffer is offered to the TAP one snapshot at a time.
    c_nxt.oack_sync = {c_r.oack_sync[1:0], t_r.out_ack_tgl};
    if (tgl_edge(c_r.oack_sync)) begin
      c_nxt.out_busy = 1'b0;
    end
    if (c_r.hold_dirty && !c_r.out_busy) begin
      c_nxt.hold_x     = c_r.hold;
      c_nxt.out_tgl    = ~c_r.out_tgl;
      c_nxt.out_busy   = 1'b1;
      c_nxt.hold_dirty = 1'b0;
    end
    if (c_nxt.hold != c_r.hold) begin
      c_nxt.hold_dirty = 1'b1;
    end
    c_nxt.rdata = '0;
    if (reg_rd && reg_mod == `DBGBUF_MOD_DEBUG) begin
      if (reg_idx == `DBGBUF_IDX_HOLD) begin
        c_nxt.rdata = {8'h00, c_r.hold};
      end else if (reg_idx == `DBGBUF_IDX_ADDR) begin
        c_nxt.rdata = c_r.addr;
      end else if (reg_idx == `DBGBUF_IDX_FLAG) begin
        c_nxt.rdata = {8'h00, 6'h00, spe_in, c_r.transfer_complete_flag};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      c_r      <= '0;
      c_r.hold <= `DBGBUF_HOLD_RST;
      c_r.addr <= `DBGBUF_ADDR_RST;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign reg_rdata        = c_r.rdata;
  assign tap_status_clear = c_r.clr;
  assign tlr_active       = c_r.tlr_sync[1];
endmodule // dbgbuf_top
